// ==== bench/ddr_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ddr_mem_model (
  // clock
  input  wire logic       ref_clk,
  // strobe and data toward the group
  output logic            dqs,
  output logic [7:0]      dq
);
  logic       drive = 1'b0;
  logic       s_val = 1'b0;
  logic [7:0] d_val = 8'h00;
  initial begin
    dqs = 1'b0;
    dq = 8'h00;
  end
  // released lines show the inverse of the last value
  always @(negedge ref_clk) begin
    dqs <= drive ? s_val : ~dqs;
    dq  <= drive ? d_val : ~dq;
  end
  // drive strobe level and data for n cycles, or release
  task automatic phase(input logic on, input logic s,
                       input logic [7:0] d, input int n);
    @(posedge ref_clk);
    drive = on;
    s_val = s;
    d_val = d;
    repeat (n) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ==== bench/output_gearbox_and_strobe_control_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module output_gearbox_and_strobe_control_sva (
  // clocks and reset
  input wire logic                           ref_clk,
  input wire logic                           edge_clk,
  input wire logic                           rst,
  // gearbox
  input wire logic                           tx_valid,
  input wire logic                           tx_ready,
  input wire gearbox_strobe_pkg::gear_mode_t gear_mode,
  input wire logic [1:0]                     ser_out,
  input wire logic                           ser_active,
  // memory side
  input wire logic                           wr_en,
  input wire logic                           dqs_oe,
  input wire logic                           dq_oe,
  input wire logic                           read_window,
  input wire gearbox_strobe_pkg::dq_pair_t   rd_data,
  input wire logic                           sync_capture_polarity,
  input wire logic                           read_capture_qualifier
);
  sequence s_take;
    tx_valid && tx_ready;
  endsequence
  sequence s_wr_stop;
    $fell(wr_en);
  endsequence
  property p_take_drops_ready;
    @(posedge ref_clk) disable iff (rst) s_take |=> !tx_ready;
  endproperty
  property p_idle_zero;
    @(posedge edge_clk) disable iff (rst) !ser_active |-> ser_out == 2'h0;
  endproperty
  property p_lane1_quiet;
    @(posedge edge_clk) disable iff (rst)
      gear_mode != gearbox_strobe_pkg::MODE_BY2_4TO1 |-> !ser_out[1];
  endproperty
  property p_qual_pulse;
    @(posedge ref_clk) disable iff (rst)
      read_capture_qualifier |=> !read_capture_qualifier;
  endproperty
  property p_data_with_qual;
    @(posedge ref_clk) disable iff (rst)
      $changed(rd_data) |-> read_capture_qualifier;
  endproperty
  property p_qual_in_read;
    @(posedge ref_clk) disable iff (rst)
      read_capture_qualifier |-> read_window || $past(read_window);
  endproperty
  property p_pol_in_read;
    @(posedge ref_clk) disable iff (rst)
      $changed(sync_capture_polarity) |-> read_window;
  endproperty
  property p_oe_follows_wr;
    @(posedge ref_clk) disable iff (rst) $rose(wr_en) |=> dqs_oe;
  endproperty
  property p_oe_release;
    @(posedge ref_clk) disable iff (rst) s_wr_stop |-> ##[2:3] !dq_oe;
  endproperty
  a_take_drops_ready: assert property (p_take_drops_ready)
    else $error("ready high after take");
  a_idle_zero: assert property (p_idle_zero)
    else $error("serial bits while idle");
  a_lane1_quiet: assert property (p_lane1_quiet)
    else $error("lane one used outside by2");
  a_qual_pulse: assert property (p_qual_pulse)
    else $error("qualifier longer than one cycle");
  a_data_with_qual: assert property (p_data_with_qual)
    else $error("read data changed without qualifier");
  a_qual_in_read: assert property (p_qual_in_read)
    else $error("qualifier outside read");
  a_pol_in_read: assert property (p_pol_in_read)
    else $error("polarity changed outside read");
  a_oe_follows_wr: assert property (p_oe_follows_wr)
    else $error("strobe not driven after write start");
  a_oe_release: assert property (p_oe_release)
    else $error("data enable held after write");
endmodule
bind output_gearbox_and_strobe_control
  output_gearbox_and_strobe_control_sva u_sva (
    .ref_clk,
    .edge_clk,
    .rst,
    .tx_valid,
    .tx_ready,
    .gear_mode,
    .ser_out,
    .ser_active,
    .wr_en,
    .dqs_oe,
    .dq_oe,
    .read_window,
    .rd_data,
    .sync_capture_polarity,
    .read_capture_qualifier
  );
`default_nettype wire

// ==== bench/output_gearbox_and_strobe_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); \
  end \
end
module output_gearbox_and_strobe_control_test;
  logic                           ref_clk = 1'b0;
  logic                           edge_clk = 1'b0;
  logic                           rst = 1'b1;
  logic [7:0]                     tx_word = 8'h00;
  logic                           tx_valid = 1'b0;
  logic                           tx_ready;
  gearbox_strobe_pkg::gear_mode_t gear_mode;
  logic [1:0]                     ser_out;
  logic                           ser_active;
  logic                           dqs_o;
  logic                           dqs_oe;
  logic [7:0]                     dq_o;
  logic                           dq_oe;
  logic [5:0]                     dll_code = 6'h02;
  logic                           read_window = 1'b0;
  logic                           wr_en = 1'b0;
  gearbox_strobe_pkg::dq_pair_t   wr_data = 16'h0000;
  gearbox_strobe_pkg::dq_pair_t   rd_data;
  logic                           read_strobe_shifted;
  logic                           write_strobe_shifted;
  logic                           sync_capture_polarity;
  logic                           read_capture_qualifier;
  logic                           mem_dqs;
  logic [7:0]                     mem_dq;
  wire logic                      dqs_i;
  wire logic [7:0]                dq_i;
  int                             errors = 0;
  int                             comparisons = 0;

  initial gear_mode = gearbox_strobe_pkg::MODE_SER_7TO1;
  assign dqs_i = dqs_oe ? dqs_o : mem_dqs;
  assign dq_i = dq_oe ? dq_o : mem_dq;

  always #2 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #24 edge_clk = ~edge_clk;
  end

  output_gearbox_and_strobe_control uut (
    .ref_clk, .rst, .edge_clk, .tx_word, .tx_valid, .tx_ready,
    .gear_mode, .ser_out, .ser_active, .dqs_i, .dqs_o, .dqs_oe,
    .dq_i, .dq_o, .dq_oe, .dll_code, .read_window, .wr_en, .wr_data,
    .rd_data, .read_strobe_shifted, .write_strobe_shifted,
    .sync_capture_polarity, .read_capture_qualifier
  );
  ddr_mem_model mem (.ref_clk, .dqs(mem_dqs), .dq(mem_dq));

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic timeout_hit();
    errors++;
    end_of_test();
  endtask

  task automatic gear(input int m, input logic [7:0] w);
    int n;
    int len;
    logic [7:0] g0;
    logic [7:0] g1;
    logic [7:0] got;
    len = m == 0 ? 7 : (m == 1 ? 8 : 4);
    @(negedge ref_clk);
    for (n = 0; n < 80 && tx_ready !== 1'b1; n++) @(negedge ref_clk);
    if (n == 80) timeout_hit();
    gear_mode = gearbox_strobe_pkg::gear_mode_t'(m);
    tx_word = w;
    tx_valid = 1'b1;
    @(negedge ref_clk);
    tx_valid = 1'b0;
    `CHK(tx_ready, 1'b0)
    for (n = 0; n < 40 && ser_active !== 1'b1; n++) @(negedge edge_clk);
    if (n == 40) timeout_hit();
    for (n = 0; n < len; n++) begin
      g0[n] = ser_out[0];
      g1[n] = ser_out[1];
      @(negedge edge_clk);
    end
    `CHK(ser_active, 1'b0)
    got = m == 2 ? {g1[3:0], g0[3:0]} : (m == 0 ? {1'b0, g0[6:0]} : g0);
    `CHK(got, m == 0 ? {1'b0, w[6:0]} : w)
  endtask

  task automatic do_read(input logic [5:0] code, input logic [7:0] r, f);
    int n;
    logic pol;
    @(negedge ref_clk);
    dll_code = code;
    mem.phase(1'b1, 1'b0, ~r, 12);
    @(negedge ref_clk);
    read_window = 1'b1;
    fork
      begin
        mem.phase(1'b1, 1'b0, ~r, 8);
        mem.phase(1'b1, 1'b1, r, 20);
        mem.phase(1'b1, 1'b0, f, 20);
      end
      begin
        for (n = 0; n < 40 && mem_dqs !== 1'b1; n++) @(negedge ref_clk);
        if (n == 40) timeout_hit();
        // two sync stages, code+1 taps, one register; seen one edge late
        for (n = 0; n < 80 && read_strobe_shifted !== 1'b1; n++)
          @(negedge ref_clk);
        `CHK(n, int'(code) + 3)
        for (n = 0; n < 100 && read_capture_qualifier !== 1'b1; n++)
          @(negedge ref_clk);
        if (n == 100) timeout_hit();
        `CHK(rd_data, {r, f})
      end
    join
    mem.phase(1'b0, 1'b0, 8'h00, 1);
    @(negedge ref_clk);
    pol = sync_capture_polarity;
    read_window = 1'b0;
    repeat (10) @(negedge ref_clk);
    `CHK(sync_capture_polarity, pol)
  endtask

  task automatic do_write(input logic [7:0] r, f);
    int n;
    logic p;
    logic s;
    @(negedge ref_clk);
    wr_en = 1'b1;
    wr_data = {r, f};
    @(negedge ref_clk);
    `CHK(dqs_oe, 1'b1)
    for (n = 0; n < 20 && dq_oe !== 1'b1; n++) @(negedge ref_clk);
    if (n == 20) timeout_hit();
    p = write_strobe_shifted;
    for (n = 0; n < 8; n++) begin
      s = dqs_o;
      @(negedge ref_clk);
      `CHK(dq_o, p ? r : f)
      `CHK(dqs_o, ~s)
      p = write_strobe_shifted;
    end
    wr_en = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(dq_oe, 1'b0)
  endtask

  initial begin
    repeat (4) @(negedge ref_clk);
    `CHK(tx_ready, 1'b1)
    `CHK(read_capture_qualifier, 1'b0)
    `CHK(dq_oe, 1'b0)
    rst = 1'b0;
    gear(0, 8'hd3);
    gear(1, 8'h96);
    gear(2, 8'h5b);
    do_read(6'h02, 8'h3a, 8'hc5);
    do_read(6'h05, 8'h71, 8'h8e);
    do_write(8'he1, 8'h1e);
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== core/output_gearbox_and_strobe_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module output_gearbox_and_strobe_control #(
  parameter int DQ_W   = 8,
  parameter int GEAR_W = 8
) (
  // system clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // high-speed edge clock
  input  wire logic                          edge_clk,
  // gearbox core side
  input  wire logic [GEAR_W-1:0]             tx_word,
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  input  wire gearbox_strobe_pkg::gear_mode_t gear_mode,
  // gearbox serial pins
  output logic [1:0]                         ser_out,
  output logic                               ser_active,
  // memory strobe pin
  input  wire logic                          dqs_i,
  output logic                               dqs_o,
  output logic                               dqs_oe,
  // memory data pins
  input  wire logic [DQ_W-1:0]               dq_i,
  output logic [DQ_W-1:0]                    dq_o,
  output logic                               dq_oe,
  // calibration from delay loop
  input  wire logic [5:0]                    dll_code,
  // memory core side
  input  wire logic                          read_window,
  input  wire logic                          wr_en,
  input  wire gearbox_strobe_pkg::dq_pair_t  wr_data,
  output gearbox_strobe_pkg::dq_pair_t       rd_data,
  // group control outputs
  output logic                               read_strobe_shifted,
  output logic                               write_strobe_shifted,
  output logic                               sync_capture_polarity,
  output logic                               read_capture_qualifier
);

  generate
    if (DQ_W != gearbox_strobe_pkg::DQ_WIDTH ||
        GEAR_W != gearbox_strobe_pkg::GEAR_WIDTH) begin : g_bad
      $error("widths must match the package carrier types");
    end
  endgenerate

  // ------------------------------------------------------------
  // gearbox, system clock side
  // ------------------------------------------------------------
  logic [GEAR_W-1:0] word_reg;
  logic              req_tgl_reg;
  logic [1:0]        mode_word_reg;
  logic              ready_reg;
  logic              ack_s1_reg;
  logic              ack_s2_reg;
  logic              ack_tgl_reg;
  wire               tx_load;
  wire               ack_back;

  assign tx_load  = tx_valid & ready_reg;
  assign ack_back = (ack_s2_reg == req_tgl_reg);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_reg      <= '0;
      mode_word_reg <= 2'h0;
      req_tgl_reg   <= 1'b0;
    end else if (tx_load) begin
      word_reg      <= tx_word;
      mode_word_reg <= gear_mode;
      req_tgl_reg   <= ~req_tgl_reg;
    end
  end

  // ready drops on load and returns when the edge side acknowledges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ready_reg <= 1'b1;
    end else if (tx_load) begin
      ready_reg <= 1'b0;
    end else if (ack_back) begin
      ready_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  assign tx_ready = ready_reg;

  // ------------------------------------------------------------
  // gearbox, edge clock side
  // ------------------------------------------------------------
  logic              req_s1_reg;
  logic              req_s2_reg;
  logic [1:0]        shadow_mode_reg;
  logic [1:0]        frame_mode_reg;
  logic [GEAR_W-1:0] shadow_reg;
  logic              fresh_reg;
  logic [GEAR_W-1:0] shift_reg;
  logic [3:0]        cnt_reg;
  logic              active_reg;
  logic [1:0]        ser_reg;
  wire               arrive;
  wire               frame_end;
  wire               by2_mode;
  wire  [3:0]        frame_len;
  wire  [3:0]        cnt_next;
  wire               fresh_next;

  always_ff @(posedge edge_clk or posedge rst) begin
    if (rst) begin
      req_s1_reg  <= 1'b0;
      req_s2_reg  <= 1'b0;
    end else begin
      req_s1_reg  <= req_tgl_reg;
      req_s2_reg  <= req_s1_reg;
    end
  end

  // mode rides with the word; an unsent word holds off the next one
  assign arrive    = (req_s2_reg != ack_tgl_reg) & (~fresh_reg | frame_end);
  assign frame_end = (cnt_reg == 4'h0);
  assign by2_mode  = (frame_mode_reg == gearbox_strobe_pkg::MODE_BY2_4TO1);

  assign frame_len =
    (shadow_mode_reg == gearbox_strobe_pkg::MODE_SER_7TO1)
      ? gearbox_strobe_pkg::LEN_7TO1
      : ((shadow_mode_reg == gearbox_strobe_pkg::MODE_BY2_4TO1)
          ? gearbox_strobe_pkg::LEN_4TO1
          : gearbox_strobe_pkg::LEN_8TO1);

  assign cnt_next   = frame_end ? frame_len - 4'h1 : cnt_reg - 4'h1;
  // a word arriving while the old one is taken keeps the flag set
  assign fresh_next = arrive | (fresh_reg & ~frame_end);

  always_ff @(posedge edge_clk or posedge rst) begin
    if (rst) begin
      shadow_reg      <= '0;
      shadow_mode_reg <= 2'h0;
      ack_tgl_reg     <= 1'b0;
      fresh_reg       <= 1'b0;
    end else begin
      fresh_reg <= fresh_next;
      if (arrive) begin
        shadow_reg      <= word_reg;
        shadow_mode_reg <= mode_word_reg;
        ack_tgl_reg     <= req_s2_reg;
      end
    end
  end

  always_ff @(posedge edge_clk or posedge rst) begin
    if (rst) begin
      shift_reg      <= '0;
      cnt_reg        <= 4'h0;
      active_reg     <= 1'b0;
      frame_mode_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_next;
      if (frame_end) begin
        frame_mode_reg <= shadow_mode_reg;
        shift_reg  <= fresh_reg ? shadow_reg : '0;
        active_reg <= fresh_reg;
      end else begin
        shift_reg <= {1'b0, shift_reg[GEAR_W-1:1]};
      end
    end
  end

  // lane one carries the upper half only in the by-two mode
  always_ff @(posedge edge_clk or posedge rst) begin
    if (rst) begin
      ser_reg <= 2'h0;
    end else begin
      ser_reg[0] <= shift_reg[0];
      ser_reg[1] <= by2_mode & shift_reg[gearbox_strobe_pkg::LANE_SPLIT];
    end
  end

  always_ff @(posedge edge_clk or posedge rst) begin
    if (rst) begin
      ser_active <= 1'b0;
    end else begin
      ser_active <= active_reg;
    end
  end

  assign ser_out = ser_reg;

  // ------------------------------------------------------------
  // strobe pin and data pin synchronisers
  // ------------------------------------------------------------
  logic            dqs_s1_reg;
  logic            dqs_s2_reg;
  logic [DQ_W-1:0] dq_s1_reg;
  logic [DQ_W-1:0] dq_s2_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dqs_s1_reg <= 1'b0;
      dqs_s2_reg <= 1'b0;
      dq_s1_reg  <= '0;
      dq_s2_reg  <= '0;
    end else begin
      dqs_s1_reg <= dqs_i;
      dqs_s2_reg <= dqs_s1_reg;
      dq_s1_reg  <= dq_i;
      dq_s2_reg  <= dq_s1_reg;
    end
  end

  // ------------------------------------------------------------
  // calibrated strobe delay
  // ------------------------------------------------------------
  wire  rd_tap;
  wire  wr_tap;
  logic rs_reg;
  logic ws_reg;
  logic rs_prev_reg;
  logic ws_prev_reg;

  strobe_delay_line #(
    .TAPS      (gearbox_strobe_pkg::DELAY_TAPS)
  ) u_delay (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .strobe_in (dqs_s2_reg),
    .cal_code  (dll_code),
    .rd_tap    (rd_tap),
    .wr_tap    (wr_tap)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rs_reg      <= 1'b0;
      ws_reg      <= 1'b0;
      rs_prev_reg <= 1'b0;
      ws_prev_reg <= 1'b0;
    end else begin
      rs_reg      <= rd_tap;
      ws_reg      <= wr_tap;
      rs_prev_reg <= rs_reg;
      ws_prev_reg <= ws_reg;
    end
  end

  wire rs_rise = rs_reg & ~rs_prev_reg;
  wire rs_fall = ~rs_reg & rs_prev_reg;
  wire ws_rise = ws_reg & ~ws_prev_reg;

  assign read_strobe_shifted  = rs_reg;
  assign write_strobe_shifted = ws_reg;

  // ------------------------------------------------------------
  // read preamble tracking and polarity
  // ------------------------------------------------------------
  gearbox_strobe_pkg::rd_state_t rd_state_reg;
  gearbox_strobe_pkg::rd_state_t rd_state_next;
  logic phase_reg;
  logic pol_reg;
  logic resolved_reg;

  always_comb begin
    rd_state_next = rd_state_reg;
    unique case (rd_state_reg)
      gearbox_strobe_pkg::RD_IDLE: begin
        if (read_window) begin
          rd_state_next = gearbox_strobe_pkg::RD_PREAMBLE;
        end
      end
      gearbox_strobe_pkg::RD_PREAMBLE: begin
        if (!rs_reg) begin
          rd_state_next = gearbox_strobe_pkg::RD_WAIT_RISE;
        end
      end
      gearbox_strobe_pkg::RD_WAIT_RISE: begin
        if (rs_rise) begin
          rd_state_next = gearbox_strobe_pkg::RD_ACTIVE;
        end
      end
      gearbox_strobe_pkg::RD_ACTIVE: begin
        rd_state_next = gearbox_strobe_pkg::RD_ACTIVE;
      end
    endcase
    if (!read_window) begin
      rd_state_next = gearbox_strobe_pkg::RD_IDLE;
    end
  end

  wire first_rise = (rd_state_reg == gearbox_strobe_pkg::RD_WAIT_RISE)
                    & rs_rise & read_window;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_state_reg <= gearbox_strobe_pkg::RD_IDLE;
    end else begin
      rd_state_reg <= rd_state_next;
    end
  end

  // half-rate phase; the polarity picks which phase takes read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_reg    <= 1'b0;
      pol_reg      <= 1'b0;
      resolved_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      if (first_rise) begin
        pol_reg      <= phase_reg;
        resolved_reg <= 1'b1;
      end else if (rd_state_reg == gearbox_strobe_pkg::RD_IDLE) begin
        resolved_reg <= 1'b0;
      end
    end
  end

  assign sync_capture_polarity = pol_reg;

  // ------------------------------------------------------------
  // read capture on both strobe edges and resync
  // ------------------------------------------------------------
  gearbox_strobe_pkg::dq_pair_t cap_reg;
  gearbox_strobe_pkg::dq_pair_t rd_reg;
  logic pend_reg;
  logic qual_reg;
  wire  capturing;
  wire  take;

  assign capturing = resolved_reg | first_rise;
  assign take      = pend_reg & resolved_reg & (phase_reg == pol_reg);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cap_reg <= '0;
    end else begin
      if (rs_rise && capturing) begin
        cap_reg.rise <= dq_s2_reg;
      end
      if (rs_fall && capturing) begin
        cap_reg.fall <= dq_s2_reg;
      end
    end
  end

  // a new word on the take cycle keeps the pending flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (rs_fall && resolved_reg) begin
      pend_reg <= 1'b1;
    end else if (take || !resolved_reg) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_reg   <= '0;
      qual_reg <= 1'b0;
    end else begin
      qual_reg <= take;
      if (take) begin
        rd_reg <= cap_reg;
      end
    end
  end

  assign rd_data                = rd_reg;
  assign read_capture_qualifier = qual_reg;

  // ------------------------------------------------------------
  // write path
  // ------------------------------------------------------------
  logic [DQ_W-1:0] q0_reg;
  logic [DQ_W-1:0] q1_reg;
  logic [DQ_W-1:0] dq_out_reg;
  logic            oe_stage_reg;
  logic            dq_oe_reg;
  logic            dqs_out_reg;
  logic            dqs_oe_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q0_reg <= '0;
      q1_reg <= '0;
    end else if (wr_en) begin
      q0_reg <= wr_data.rise;
      q1_reg <= wr_data.fall;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dq_out_reg <= '0;
    end else begin
      dq_out_reg <= ws_reg ? q0_reg : q1_reg;
    end
  end

  // enable waits for a write strobe rise to turn on; it turns off two cycles after wr_en drops, without the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oe_stage_reg <= 1'b0;
      dq_oe_reg    <= 1'b0;
    end else begin
      oe_stage_reg <= wr_en;
      if (ws_rise || !oe_stage_reg) begin
        dq_oe_reg <= oe_stage_reg;
      end
    end
  end

  // strobe toggles while writing, floats otherwise for the memory
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dqs_out_reg <= 1'b0;
      dqs_oe_reg  <= 1'b0;
    end else begin
      dqs_oe_reg  <= wr_en;
      dqs_out_reg <= wr_en & ~dqs_out_reg;
    end
  end

  assign dq_o   = dq_out_reg;
  assign dq_oe  = dq_oe_reg;
  assign dqs_o  = dqs_out_reg;
  assign dqs_oe = dqs_oe_reg;

endmodule
`default_nettype wire

// ==== core/strobe_delay_line.sv ====
`timescale 1ns/1ps
`default_nettype none
module strobe_delay_line #(
  parameter int TAPS = 64
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // strobe in, calibration
  input  wire logic       strobe_in,
  input  wire logic [5:0] cal_code,
  // delayed strobes
  output logic            rd_tap,
  output logic            wr_tap
);

  logic [TAPS-1:0] chain_reg;
  wire  [5:0]      wr_sel;

  generate
    if (TAPS != gearbox_strobe_pkg::DELAY_TAPS) begin : g_bad
      $error("delay line must have one tap per calibration code");
    end
  endgenerate

  // one flop per tap; the code picks how far down the strobe has walked
  genvar t;
  generate
    for (t = 0; t < TAPS; t++) begin : g_tap
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          chain_reg[t] <= 1'b0;
        end else begin
          chain_reg[t] <= (t == 0) ? strobe_in : chain_reg[(t == 0) ? 0 : t-1];
        end
      end
    end
  endgenerate

  // write strobe sits one tap later, clamped at the end of the line
  assign wr_sel = (cal_code == gearbox_strobe_pkg::CAL_MAX) ? cal_code
                : cal_code + gearbox_strobe_pkg::WR_TAP_OFFSET;
  assign rd_tap = chain_reg[cal_code];
  assign wr_tap = chain_reg[wr_sel];

endmodule
`default_nettype wire

// ==== inc/gearbox_strobe_pkg.sv ====
package gearbox_strobe_pkg;

  localparam int GEAR_WIDTH   = 8;
  localparam int DQ_WIDTH     = 8;
  localparam int CAL_WIDTH    = 6;
  localparam int DELAY_TAPS   = 64;
  localparam int LANE_SPLIT   = 4;

  localparam logic [3:0] LEN_7TO1 = 4'h7;
  localparam logic [3:0] LEN_8TO1 = 4'h8;
  localparam logic [3:0] LEN_4TO1 = 4'h4;

  localparam logic [5:0] WR_TAP_OFFSET = 6'h01;
  localparam logic [5:0] CAL_MAX       = 6'h3f;

  typedef enum logic [1:0] {
    MODE_SER_7TO1,
    MODE_BY4_8TO1,
    MODE_BY2_4TO1
  } gear_mode_t;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_PREAMBLE,
    RD_WAIT_RISE,
    RD_ACTIVE
  } rd_state_t;

  typedef struct packed {
    logic [DQ_WIDTH-1:0] rise;
    logic [DQ_WIDTH-1:0] fall;
  } dq_pair_t;

endpackage
